// file: rtl/pcr_config_regs.sv
// Behaviour
// [R1] Bus reset: off, reload, clear faults, restart
// [R2] Bus reset is send-byte, no data
// [R3] Mode byte 0xd4, paged, default 0xc1
// [R4] Compensation byte 0xd3, paged, default 0x70
// [R5] Phase config byte 0xf5, shared, default 0x10
// [R6] Frequency word 0x33, shared, default 0xfabc
// [R7] Running channel: only mode bits 0,6
// [R8] Mode bit 7 selects current range
// [R9] Mode bit 6 servo, not off/ramping
// [R10] Mode bit 5 selects temperature method
// [R11] Mode bit 1 selects output voltage range
// [R12] Range bits frozen while output active
// [R13] Bit 0 forced continuous, discontinuous while ramping
// [R14] Compensation [7:5] selects amplifier gain
// [R15] Compensation [4:0] selects resistor code
// [R16] Phase write refused unless both off
// [R17] Phase bit 7 shares feedback node
// [R18] Phase [6:5] selects input sense gain
// [R19] Phase bit 4 gates shared clock low
// [R20] Phase [2:0] selects channel phase offsets
// [R21] Frequency write refused unless off
// [R22] Bad packet check: no write, fault
// [R23] Reserved bits read zero, ignored
`timescale 1ns/1ps
`default_nettype none
`include "pcr_defs.svh"

module pcr_config_regs (
    input  wire logic        clk,            // 20 MHz controller clock
    input  wire logic        reset_n,        // Power-on reset, async
    input  wire logic        cmdValid,       // One-cycle decoded command
    input  wire logic        cmdWrite,       // 1 write, 0 read
    input  wire logic [7:0]  cmdCode,        // Command code
    input  wire logic        cmdPage,        // Addressed channel
    input  wire logic [1:0]  cmdLen,         // Data bytes in write
    input  wire logic [15:0] cmdData,        // Write data, low byte first
    input  wire logic        pecOk,          // Packet check byte valid
    input  wire logic [1:0]  runPin,         // Run pins, asynchronous
    input  wire logic [1:0]  chanOn,         // Channel commanded on
    input  wire logic [1:0]  chanRamping,    // Channel ramping on/off
    input  wire logic        vinAboveOn,     // Input above turn-on level
    input  wire logic        vinBelowOff,    // Input below turn-off level
    input  wire logic        nvmDone,        // Nonvolatile reload finished
    output logic [15:0]      rdData,         // Read answer
    output logic             ack,            // Command accepted pulse
    output logic             nack,           // Command refused pulse
    output logic             commFault,      // Communication fault pulse
    output logic             busyFault,      // Busy fault pulse
    output logic             clearFaults,    // Clear all faults pulse
    output logic             forceOff,       // Hold both channels off
    output logic             nvmLoad,        // Reload request pulse
    output logic             softStart,      // Restart enabled channels
    output logic [1:0]       highCurrent,    // Current-limit high range
    output logic [1:0]       servoEn,        // Output servo active
    output logic [1:0]       directTemp,     // Direct voltage temp sense
    output logic [1:0]       lowVoltRange,   // Output limited to 7 V
    output logic [1:0]       forcedCont,     // Forced continuous active
    output logic [5:0]       eaGmCode,       // Amp gain, ch1:ch0
    output logic [9:0]       rithCode,       // Resistor code, ch1:ch0
    output logic             feedbackShare,  // Ch1 uses ch0 feedback
    output logic [1:0]       senseGain,      // Input sense gain code
    output logic             shareClkLow,    // Pull shared clock low
    output logic [2:0]       phaseCode,      // Phase offset code
    output logic [15:0]      freqSetting     // Switching frequency word
);

    pcr_pkg::pcr_state_t cur;
    pcr_pkg::pcr_state_t next_cur;

    logic [1:0] running;     // Channel running, per synchronised pin
    logic       anyRun;      // Either channel running
    logic       inIdle;      // No bus reset sequence under way
    logic       isWrite;     // Decoded write this cycle
    logic       isRead;      // Decoded read this cycle
    logic       pecBad;      // Write whose packet check failed
    logic [7:0] oldMode;     // Stored mode of the addressed channel
    logic [7:0] newMode;     // Written mode, reserved bits dropped
    logic [7:0] modeDiff;    // Frozen mode bits the write would change
    logic       modeLocked;  // Write touches a bit frozen while running
    logic       writeOk;     // Write that may be processed
    logic       readOk;      // Read that may be answered
    logic [1:0] gainField;   // Stored input sense gain code
    logic [2:0] offsetField; // Stored phase offset code
    logic       vinLow;      // Input outside the start window

    // Channel running when its synchronised run pin is high and it is on.
    // The raw pins never reach this logic; only the second flop is read.
    assign running = cur.runSync2 & chanOn;
    assign anyRun  = |running;

    // Commands are only decoded outside the bus reset sequence, so a
    // host cannot alter a register that the reload is about to overwrite
    assign inIdle  = (cur.rstState == pcr_pkg::PCR_IDLE);
    assign isWrite = cmdValid & cmdWrite;
    assign isRead  = cmdValid & ~cmdWrite;
    assign pecBad  = isWrite & ~pecOk & inIdle;

    // Next-state logic: decode, write guards and the bus reset sequence
    always_comb begin
        next_cur             = cur;
        next_cur.runSync1    = runPin;
        next_cur.runSync2    = cur.runSync1;
        next_cur.ack         = 1'b0;
        next_cur.nack        = 1'b0;
        next_cur.commFault   = 1'b0;
        next_cur.busyFault   = 1'b0;
        next_cur.clearFaults = 1'b0;
        next_cur.nvmLoad     = 1'b0;
        next_cur.softStart   = 1'b0;
        oldMode    = cur.mode[cmdPage];
        newMode    = cmdData[7:0] & `PCR_MODE_RW_MASK;          // [R23]
        // Only the servo and conduction bits may move on a live channel
        modeDiff   = (newMode ^ oldMode) & ~`PCR_MODE_LIVE_MASK;
        modeLocked = (modeDiff != 8'h00);
        writeOk    = isWrite & pecOk & inIdle;
        readOk     = isRead & inIdle;

        // Bad packet check drops the write and flags a comm fault;
        // nothing else is answered, so the host sees no acknowledge
        if (pecBad) begin
            next_cur.commFault = 1'b1;                          // [R22]
        end

        if (writeOk) begin
            unique case (cmdCode)
                // Bus reset is a bare command code
                `PCR_CMD_RESET: begin
                    if (cmdLen == 2'd0) begin                   // [R2]
                        next_cur.ack      = 1'b1;
                        next_cur.forceOff = 1'b1;               // [R1]
                        next_cur.rstState = pcr_pkg::PCR_SHUTDOWN;
                    end else begin
                        next_cur.commFault = 1'b1;
                    end
                end
                `PCR_CMD_MODE: begin
                    // Running channel: only bits 0 and 6 may differ;
                    // both range bits change loop gain, so they freeze
                    if (running[cmdPage] && modeLocked) begin   // [R7] [R12]
                        next_cur.commFault = 1'b1;
                    end else begin
                        next_cur.mode[cmdPage] = newMode;       // [R3]
                        next_cur.ack = 1'b1;
                    end
                end
                // Compensation codes take effect at once
                `PCR_CMD_COMP: begin
                    next_cur.comp[cmdPage] = cmdData[7:0];      // [R4]
                    next_cur.ack = 1'b1;
                end
                // Phase and sharing only change with both channels stopped
                `PCR_CMD_PHASE: begin
                    if (anyRun) begin                           // [R16]
                        next_cur.nack      = 1'b1;
                        next_cur.busyFault = 1'b1;
                    end else begin
                        next_cur.phase = cmdData[7:0]
                                         & `PCR_PH_RW_MASK;     // [R5]
                        next_cur.ack = 1'b1;
                    end
                end
                // Oscillator must not be retuned under a running channel
                `PCR_CMD_FREQ: begin
                    if (anyRun) begin                           // [R21]
                        next_cur.nack      = 1'b1;
                        next_cur.busyFault = 1'b1;
                    end else begin
                        next_cur.freq = cmdData;                // [R6]
                        next_cur.ack  = 1'b1;
                    end
                end
                // Unknown codes are refused
                default: next_cur.nack = 1'b1;
            endcase
        end

        // Read path; the answer is registered so it stands with the
        // acknowledge, whatever the host does to the code afterwards
        if (readOk) begin
            next_cur.ack = 1'b1;
            unique case (cmdCode)
                `PCR_CMD_MODE:  next_cur.rdData = {8'h00, cur.mode[cmdPage]};
                `PCR_CMD_COMP:  next_cur.rdData = {8'h00, cur.comp[cmdPage]};
                `PCR_CMD_PHASE: next_cur.rdData = {8'h00, cur.phase};
                `PCR_CMD_FREQ:  next_cur.rdData = cur.freq;
                default: begin
                    next_cur.rdData = 16'h0000;
                    next_cur.nack   = 1'b1;
                    next_cur.ack    = 1'b0;
                end
            endcase
        end

        // Bus reset sequence: off, reload, clear, restart
        unique case (cur.rstState)
            pcr_pkg::PCR_IDLE: ;
            // Channels held off; ask for the stored image
            pcr_pkg::PCR_SHUTDOWN: begin
                next_cur.nvmLoad  = 1'b1;                       // [R1]
                next_cur.rstState = pcr_pkg::PCR_RELOAD;
            end
            pcr_pkg::PCR_RELOAD: begin
                // Working copy returns to stored defaults on reload
                if (nvmDone) begin
                    next_cur.mode[0]     = `PCR_MODE_RST;
                    next_cur.mode[1]     = `PCR_MODE_RST;
                    next_cur.comp[0]     = `PCR_COMP_RST;
                    next_cur.comp[1]     = `PCR_COMP_RST;
                    next_cur.phase       = `PCR_PHASE_RST;
                    next_cur.freq        = `PCR_FREQ_RST;
                    next_cur.clearFaults = 1'b1;                // [R1]
                    next_cur.rstState    = pcr_pkg::PCR_RESTART;
                end
            end
            // Release the channels; enabled ones soft-start
            pcr_pkg::PCR_RESTART: begin
                next_cur.forceOff  = 1'b0;
                next_cur.softStart = 1'b1;                      // [R1]
                next_cur.rstState  = pcr_pkg::PCR_IDLE;
            end
        endcase
    end

    // State register
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            // Registers start at their stored defaults, pulses low
            cur.freq        <= `PCR_FREQ_RST;
            cur.comp[0]     <= `PCR_COMP_RST;
            cur.comp[1]     <= `PCR_COMP_RST;
            cur.mode[0]     <= `PCR_MODE_RST;
            cur.mode[1]     <= `PCR_MODE_RST;
            cur.phase       <= `PCR_PHASE_RST;
            cur.rdData      <= 16'h0000;
            cur.ack         <= 1'b0;
            cur.nack        <= 1'b0;
            cur.commFault   <= 1'b0;
            cur.busyFault   <= 1'b0;
            cur.clearFaults <= 1'b0;
            cur.forceOff    <= 1'b0;
            cur.nvmLoad     <= 1'b0;
            cur.softStart   <= 1'b0;
            cur.rstState    <= pcr_pkg::PCR_IDLE;
            // Run pins read as stopped until they have crossed
            cur.runSync1    <= 2'h0;
            cur.runSync2    <= 2'h0;
        end else begin
            cur <= next_cur;
        end
    end

    // Read answer straight from its flops
    assign rdData      = cur.rdData;

    // Handshake and fault pulses, one cycle after the taking edge
    assign ack         = cur.ack;
    assign nack        = cur.nack;
    assign commFault   = cur.commFault;
    assign busyFault   = cur.busyFault;

    // Bus reset sequence controls
    assign clearFaults = cur.clearFaults;
    assign forceOff    = cur.forceOff;
    assign nvmLoad     = cur.nvmLoad;
    assign softStart   = cur.softStart;

    // Frequency word goes to the oscillator as stored
    assign freqSetting = cur.freq;

    // Per-channel mode and compensation decode; servo and forced
    // continuous are gated by live status, the rest follow the byte
    for (genvar ch = 0; ch < 2; ch++) begin : gChan
        assign highCurrent[ch]  = cur.mode[ch][`PCR_MODE_ILIM];   // [R8]
        assign servoEn[ch]      = cur.mode[ch][`PCR_MODE_SERVO]
                                  & running[ch] & ~chanRamping[ch]; // [R9]
        assign directTemp[ch]   = cur.mode[ch][`PCR_MODE_TSNS];   // [R10]
        assign lowVoltRange[ch] = cur.mode[ch][`PCR_MODE_VRANGE]; // [R11]
        assign forcedCont[ch]   = cur.mode[ch][`PCR_MODE_FCCM]
                                  & ~chanRamping[ch];             // [R13]
        assign eaGmCode[ch*3 +: 3] = cur.comp[ch][7:5];           // [R14]
        assign rithCode[ch*5 +: 5] = cur.comp[ch][4:0];           // [R15]
    end

    // Stored phase fields
    assign gainField   = cur.phase[`PCR_PH_GAIN_HI:`PCR_PH_GAIN_LO];
    assign offsetField = cur.phase[2:0];

    // Feedback sharing only makes sense for multiphase operation
    assign feedbackShare = cur.phase[`PCR_PH_SHAREFB];            // [R17]

    // Reserved gain code falls back to the lowest gain
    assign senseGain = (gainField == `PCR_GAIN_RSVD) ? 2'h0
                       : gainField;                               // [R18] [R23]

    // Shared clock held low outside the input start window; the
    // thresholds themselves are compared elsewhere
    assign vinLow      = ~vinAboveOn | vinBelowOff;
    assign shareClkLow = cur.phase[`PCR_PH_SHARECLK] & vinLow;    // [R19]

    // Unlisted phase codes fall back to code zero
    assign phaseCode = (offsetField > `PCR_PHASE_MAXCODE) ? 3'h0
                       : offsetField;                             // [R20] [R23]

endmodule : pcr_config_regs
`default_nettype wire

// file: rtl/pcr_defs.svh
`ifndef PCR_DEFS_SVH
`define PCR_DEFS_SVH

// Command codes
`define PCR_CMD_FREQ        8'h33
`define PCR_CMD_COMP        8'hd3
`define PCR_CMD_MODE        8'hd4
`define PCR_CMD_PHASE       8'hf5
`define PCR_CMD_RESET       8'hfd

// Reset and nonvolatile defaults
`define PCR_FREQ_RST        16'hfabc
`define PCR_COMP_RST        8'h70
`define PCR_MODE_RST        8'hc1
`define PCR_PHASE_RST       8'h10

// Mode field positions
`define PCR_MODE_ILIM       7
`define PCR_MODE_SERVO      6
`define PCR_MODE_TSNS       5
`define PCR_MODE_VRANGE     1
`define PCR_MODE_FCCM       0
// Bits that may change while a channel runs
`define PCR_MODE_LIVE_MASK  8'h41
// Writable bits; [4:2] reserved
`define PCR_MODE_RW_MASK    8'he3

// Phase config fields
`define PCR_PH_SHAREFB      7
`define PCR_PH_GAIN_HI      6
`define PCR_PH_GAIN_LO      5
`define PCR_PH_SHARECLK     4
`define PCR_PH_RW_MASK      8'hf7
`define PCR_GAIN_RSVD       2'h3
`define PCR_PHASE_MAXCODE   3'h5

`endif

// file: rtl/pcr_pkg.sv
package pcr_pkg;
    typedef enum logic [1:0] {
        PCR_IDLE,
        PCR_SHUTDOWN,
        PCR_RELOAD,
        PCR_RESTART
    } pcr_rst_state_t;

    typedef struct packed {
        logic [15:0]    freq;
        logic [1:0][7:0] comp;
        logic [1:0][7:0] mode;
        logic [7:0]     phase;
        logic [15:0]    rdData;
        logic           ack;
        logic           nack;
        logic           commFault;
        logic           busyFault;
        logic           clearFaults;
        logic           forceOff;
        logic           nvmLoad;
        logic           softStart;
        pcr_rst_state_t rstState;
        logic [1:0]     runSync1;
        logic [1:0]     runSync2;
    } pcr_state_t;
endpackage : pcr_pkg

// file: verification/pcr_config_regs_properties.sv
`timescale 1ns/1ps
`default_nettype none
module pcr_config_regs_props (
    input wire logic        clk, reset_n, cmdValid, cmdWrite, cmdPage, pecOk,
    input wire logic [7:0]  cmdCode,                     // Command code
    input wire logic [1:0]  cmdLen, runPin, chanOn, chanRamping,
    input wire logic [15:0] cmdData, freqSetting,        // Data, frequency
    input wire logic        ack, nack, commFault, busyFault, clearFaults,
    input wire logic        forceOff, nvmLoad, softStart,
    input wire logic [1:0]  highCurrent, directTemp, lowVoltRange,
    input wire logic [1:0]  servoEn, forcedCont          // Gated modes
);
    default clocking @(posedge clk); endclocking
    default disable iff (!reset_n);
    // Good writes outside a bus reset sequence
    wire       wr  = cmdValid && cmdWrite && pecOk && !forceOff;
    wire [1:0] run = runPin & chanOn;
    wire       hit = wr && cmdCode == 8'hd4 && run[cmdPage] &&
        {cmdData[7], cmdData[5], cmdData[1]} != {highCurrent[cmdPage],
        directTemp[cmdPage], lowVoltRange[cmdPage]};
    logic [1:0] runQ;
    logic [1:0] stab;
    // Run pins only count once steady past the two-flop synchroniser
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            runQ <= 2'h0;
            stab <= 2'h0;
        end else begin
            runQ <= runPin;
            stab <= (runPin != runQ) ? 2'h0 : stab + {1'b0, stab != 2'h3};
        end
    end
    wire settled = stab == 2'h3 && runPin == runQ;
    rst_seq_a: assert property (wr && cmdCode == 8'hfd && cmdLen == 2'h0
        |=> ack && forceOff ##1 nvmLoad) else $error("bus reset start");
    rst_end_a: assert property (clearFaults |=> softStart && !forceOff)
        else $error("no restart after reload");
    rst_data_a: assert property (wr && cmdCode == 8'hfd && cmdLen != 2'h0
        |=> commFault && !ack) else $error("reset with data accepted");
    bad_pec_a: assert property (cmdValid && cmdWrite && !pecOk && !forceOff
        |=> commFault && !ack) else $error("bad check byte accepted");
    freq_busy_a: assert property (wr && cmdCode == 8'h33 && run != 0
        && settled |=> nack && busyFault) else $error("freq not refused");
    phase_busy_a: assert property (wr && cmdCode == 8'hf5 && run != 0
        && settled |=> nack && busyFault) else $error("phase not refused");
    freq_write_a: assert property (wr && cmdCode == 8'h33 && chanOn == 0
        |=> ack && freqSetting == $past(cmdData)) else $error("freq lost");
    mode_lock_a: assert property (hit && settled
        |=> commFault && !ack && $stable(highCurrent)) else $error("mode lock");
    ramp_gate_a: assert property (((servoEn | forcedCont) & chanRamping) == 0)
        else $error("servo or continuous while ramping");
    cover property (wr && cmdCode == 8'hfd ##1 ack);
    cover property (nack && busyFault);
    cover property (hit && settled ##1 commFault);
endmodule : pcr_config_regs_props
bind pcr_config_regs pcr_config_regs_props pcr_config_regs_props_inst (
    .clk, .reset_n, .cmdValid, .cmdWrite, .cmdPage, .pecOk, .cmdCode, .cmdLen,
    .runPin, .chanOn, .chanRamping, .cmdData, .freqSetting, .ack, .nack,
    .commFault, .busyFault, .clearFaults, .forceOff, .nvmLoad, .softStart,
    .highCurrent, .directTemp, .lowVoltRange, .servoEn, .forcedCont);
`default_nettype wire

// file: verification/pcr_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module pcr_host_model (
    input  wire logic        clk,                          // Bus clock
    input  wire logic        ack, nack, commFault, busyFault,
    input  wire logic [15:0] rdData,                       // Read answer
    output logic             cmdValid, cmdWrite, cmdPage, pecOk,
    output logic [7:0]       cmdCode,                      // Command code
    output logic [1:0]       cmdLen,                       // Data bytes
    output logic [15:0]      cmdData                       // Write data
);
    logic [15:0] rRd;
    logic [3:0]  rFlags;   // ack, nack, commFault, busyFault
    initial {cmdValid, cmdWrite, cmdPage, pecOk, cmdCode, cmdLen, cmdData} = 30'h0;
    // Request held over the taking edge, answer read in the next cycle
    task automatic send(input logic w, input logic [7:0] c, input logic p,
                        input logic [1:0] n, input logic [15:0] d, input logic ok);
        @(negedge clk);
        {cmdValid, cmdWrite, cmdCode, cmdPage, cmdLen, cmdData, pecOk} =
            {1'b1, w, c, p, n, d, ok};
        @(negedge clk);
        rFlags = {ack, nack, commFault, busyFault};
        rRd = rdData;
        cmdValid = 1'b0;
        cmdData = ~d;      // Released data must not look stale
    endtask : send
endmodule : pcr_host_model
`default_nettype wire

// file: verification/tb_pcr_config_regs.sv
`timescale 1ns/1ps
`default_nettype none
module tb_pcr_config_regs;
    logic clk = 1'b0, reset_n = 1'b0, vinAboveOn = 1'b0, vinBelowOff = 1'b1;
    logic [1:0] runPin = 2'h0, chanOn = 2'h0, chanRamping = 2'h0;
    logic cmdValid, cmdWrite, cmdPage, pecOk, ack, nack, commFault, busyFault;
    logic clearFaults, forceOff, nvmLoad, softStart, feedbackShare, shareClkLow;
    logic [1:0] cmdLen, senseGain, highCurrent, servoEn, directTemp;
    logic [1:0] lowVoltRange, forcedCont;
    logic [7:0] cmdCode;
    logic [15:0] cmdData, rdData, freqSetting;
    logic [5:0] eaGmCode;
    logic [9:0] rithCode;
    logic [2:0] phaseCode;
    logic [3:0] nvmSr = 4'h0;
    wire nvmDone = nvmSr[3];
    int mismatches = 0, n_compared = 0;
    pcr_config_regs pcr_config_regs_inst (.clk, .reset_n, .cmdValid, .cmdWrite,
        .cmdCode, .cmdPage, .cmdLen, .cmdData, .pecOk, .runPin, .chanOn,
        .chanRamping, .vinAboveOn, .vinBelowOff, .nvmDone, .rdData, .ack, .nack,
        .commFault, .busyFault, .clearFaults, .forceOff, .nvmLoad, .softStart,
        .highCurrent, .servoEn, .directTemp, .lowVoltRange, .forcedCont,
        .eaGmCode, .rithCode, .feedbackShare, .senseGain, .shareClkLow,
        .phaseCode, .freqSetting);
    pcr_host_model pcr_host_model_inst (.clk, .ack, .nack, .commFault,
        .busyFault, .rdData, .cmdValid, .cmdWrite, .cmdPage, .pecOk, .cmdCode,
        .cmdLen, .cmdData);
    always #25 clk = ~clk;
    // Reload finishes four cycles after it is asked for
    always @(negedge clk) nvmSr <= {nvmSr[2:0], nvmLoad};
    task automatic cmp(input string nm, input logic [15:0] e, g);
        n_compared++;
        if (g !== e) begin
            mismatches++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask : cmp
    task automatic rd(input logic [7:0] c, input logic p, input logic [15:0] e);
        pcr_host_model_inst.send(1'b0, c, p, 2'h0, 16'h0, 1'b1);
        cmp("read", e, (c == 8'h33) ? pcr_host_model_inst.rRd
            : {8'h0, pcr_host_model_inst.rRd[7:0]});
    endtask : rd
    task automatic wr(input logic [7:0] c, input logic p, input logic [15:0] d,
                      input logic [3:0] f, input logic ok = 1'b1);
        pcr_host_model_inst.send(1'b1, c, p, (c == 8'h33) ? 2'h2 : 2'h1, d, ok);
        cmp("answer", {12'h0, f}, {12'h0, pcr_host_model_inst.rFlags});
    endtask : wr
    task automatic t_defaults;
        rd(8'h33, 1'b0, 16'hfabc);
        cmp("read ack", 16'h8, {12'h0, pcr_host_model_inst.rFlags});
        rd(8'hd3, 1'b1, 16'h0070);
        rd(8'hd4, 1'b0, 16'h00c1);
        rd(8'hd4, 1'b1, 16'h00c1);
        rd(8'hf5, 1'b0, 16'h0010);
        cmp("gm rith", 16'h6e10, {eaGmCode, rithCode});
        cmp("ranges", 16'h0c, {12'h0, highCurrent, lowVoltRange});
        vinAboveOn = 1'b1;
        vinBelowOff = 1'b0;
        @(negedge clk);
        cmp("clock free", 16'h0, {15'h0, shareClkLow});
        vinBelowOff = 1'b1;
        @(negedge clk);
        cmp("clock low", 16'h1, {15'h0, shareClkLow});
        vinAboveOn = 1'b0;
    endtask : t_defaults
    // Both channels off: reserved bits dropped, phase codes 0 to 5 set
    task automatic t_idle_writes;
        wr(8'hd4, 1'b1, 16'h00be, 4'h8);
        rd(8'hd4, 1'b1, 16'h00a2);
        cmp("mode", 16'h3a, {highCurrent, lowVoltRange, directTemp});
        wr(8'hd3, 1'b0, 16'h00ff, 4'h8);
        cmp("gm rith", 16'h7e1f, {eaGmCode, rithCode});
        wr(8'hf5, 1'b0, 16'h00dd, 4'h8);
        rd(8'hf5, 1'b0, 16'h00d5);
        cmp("phase", 16'h35, {feedbackShare, senseGain, phaseCode});
        for (int c = 0; c < 6; c++) begin
            wr(8'hf5, 1'b0, {13'h0, c[2:0]}, 4'h8);
            cmp("code", {13'h0, c[2:0]}, {shareClkLow, phaseCode});
        end
        wr(8'hf5, 1'b0, 16'h007e, 4'h8);
        cmp("rsvd phase", 16'h0, {11'h0, senseGain, phaseCode});
        wr(8'h33, 1'b0, 16'h02ee, 4'h8);
        cmp("freq", 16'h02ee, freqSetting);
    endtask : t_idle_writes
    // Channel 0 running, channel 1 off
    task automatic t_running;
        runPin = 2'h3;
        chanOn = 2'h1;
        repeat (4) @(negedge clk);
        wr(8'hd4, 1'b0, 16'h0080, 4'h8);
        wr(8'hd4, 1'b0, 16'h0082, 4'h2);
        wr(8'hd4, 1'b0, 16'h0000, 4'h2);
        rd(8'hd4, 1'b0, 16'h0080);
        wr(8'h33, 1'b0, 16'h1234, 4'h5);
        wr(8'hf5, 1'b0, 16'h0000, 4'h5);
        wr(8'hd4, 1'b1, 16'h0000, 4'h8);
        wr(8'hd4, 1'b0, 16'h00c1, 4'h8);
        chanRamping = 2'h1;
        @(negedge clk);
        cmp("ramp", 16'h0, {14'h0, servoEn[0], forcedCont[0]});
        chanRamping = 2'h0;
        @(negedge clk);
        cmp("steady", 16'h3, {14'h0, servoEn[0], forcedCont[0]});
        runPin = 2'h0;
        chanOn = 2'h0;
    endtask : t_running
    task automatic t_pec;
        wr(8'hd3, 1'b0, 16'h0011, 4'h2, 1'b0);
        rd(8'hd3, 1'b0, 16'h00ff);
    endtask : t_pec
    task automatic t_bus_reset;
        logic cl = 1'b0;
        logic ss = 1'b0;
        wr(8'hfd, 1'b0, 16'h0000, 4'h2);
        pcr_host_model_inst.send(1'b1, 8'hfd, 1'b0, 2'h0, 16'h0, 1'b1);
        cmp("reset", 16'h8, {12'h0, pcr_host_model_inst.rFlags});
        for (int i = 0; i < 30 && ss !== 1'b1; i++) begin
            @(negedge clk);
            cl = cl | clearFaults;
            ss = softStart;
        end
        cmp("restart", 16'h3, {14'h0, cl, ss});
        t_defaults;
    endtask : t_bus_reset
    task automatic finish_test;
        if (mismatches == 0 && n_compared > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : finish_test
    initial begin
        repeat (20) @(negedge clk);
        reset_n = 1'b1;
        t_defaults;
        t_idle_writes;
        t_running;
        t_pec;
        t_bus_reset;
        finish_test;
    end
    // Tests need about 110 cycles; 2000 leaves ample margin
    initial begin
        #100000;
        mismatches++;
        finish_test;
    end
endmodule : tb_pcr_config_regs
`default_nettype wire
